// ===== ack_master_model.sv
`default_nettype none
module ack_master_model (
  input  wire logic readout_clk,
  input  wire logic serial_digit_out,
  output var logic  shift_pulse_in,
  output var logic  power_down_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import tone_readout_pkg::*;

  initial begin
    shift_pulse_in = 1'b0;
    power_down_in  = 1'b0;
  end

  // One acknowledge pulse; bit read late in the high phase, since the fourth
  // bit gives way to the cadence soon after the fourth pulse falls
  task automatic pulse(output logic bit_seen);
    @(posedge readout_clk);
    shift_pulse_in <= 1'b1;
    repeat (7) @(posedge readout_clk);
    #1 bit_seen = serial_digit_out;
    @(posedge readout_clk);
    shift_pulse_in <= 1'b0;
    repeat (7) @(posedge readout_clk);
  endtask

  task automatic read_digit(output digit_type value);
    logic b;
    // Settling time after steering before acknowledging
    repeat (10) @(posedge readout_clk);
    for (int i = 0; i < 4; i++) begin
      pulse(b);
      value[i] = b;
    end
    repeat (10) @(posedge readout_clk);
  endtask

  // Shift pulse is already low whenever this is called
  task automatic set_power_down(input logic on);
    @(posedge readout_clk);
    power_down_in <= on;
  endtask
endmodule
`default_nettype wire

// ===== test_tone_digit_serial_readout.sv
`default_nettype none
module test_tone_digit_serial_readout;
  timeunit 1ns;
  timeprecision 1ps;
  import tone_readout_pkg::*;

  localparam int GUARD_ON  = 8;
  localparam int GUARD_OFF = 4;

  typedef struct packed {
    tone_pair_type pair;
    digit_type     code;
    logic          energy;
  } row_type;

  logic          mclk;
  logic          rstn;
  logic          readout_clk;
  logic          tone_present;
  logic          energy_detect_in;
  tone_pair_type tone_pair;
  logic          power_down_in;
  logic          shift_pulse_in;
  logic          early_tone_flag;
  logic          validated_digit_flag;
  logic          serial_digit_out;
  int            failures = 0;
  int            samples_checked = 0;
  digit_type     got;
  digit_type     bits;
  logic          extra_bit;
  row_type       rows [16] = '{
    '{4'h0, 4'h1, 1'b0}, '{4'h1, 4'h2, 1'b1}, '{4'h2, 4'h3, 1'b0}, '{4'h3, 4'hd, 1'b1},
    '{4'h4, 4'h4, 1'b0}, '{4'h5, 4'h5, 1'b1}, '{4'h6, 4'h6, 1'b0}, '{4'h7, 4'he, 1'b1},
    '{4'h8, 4'h7, 1'b0}, '{4'h9, 4'h8, 1'b1}, '{4'ha, 4'h9, 1'b0}, '{4'hb, 4'hf, 1'b1},
    '{4'hc, 4'hb, 1'b0}, '{4'hd, 4'ha, 1'b1}, '{4'he, 4'hc, 1'b0}, '{4'hf, 4'h0, 1'b1}
  };

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Link clock, unrelated in phase to mclk
  initial begin
    readout_clk = 1'b0;
    #3.3;
    forever #7.5 readout_clk = ~readout_clk;
  end

  tone_digit_serial_readout #(
    .VALIDATED_STEER  (1'b1),
    .GUARD_ON_CYCLES  (GUARD_ON),
    .GUARD_OFF_CYCLES (GUARD_OFF)
  ) u_dut (
    .mclk                 (mclk),
    .rstn                 (rstn),
    .readout_clk          (readout_clk),
    .power_down_in        (power_down_in),
    .tone_present         (tone_present),
    .tone_pair            (tone_pair),
    .energy_detect_in     (energy_detect_in),
    .shift_pulse_in       (shift_pulse_in),
    .early_tone_flag      (early_tone_flag),
    .validated_digit_flag (validated_digit_flag),
    .serial_digit_out     (serial_digit_out)
  );

  ack_master_model u_mcu (
    .readout_clk      (readout_clk),
    .serial_digit_out (serial_digit_out),
    .shift_pulse_in   (shift_pulse_in),
    .power_down_in    (power_down_in)
  );

  task automatic check(input logic [3:0] seen, input logic [3:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tone_on(input tone_pair_type pair, input logic energy);
    @(posedge mclk);
    tone_pair        <= pair;
    energy_detect_in <= energy;
    @(posedge mclk);
    tone_present <= 1'b1;
    repeat (GUARD_ON) @(posedge mclk);
    #1 check({early_tone_flag, validated_digit_flag}, 2'b10);
    repeat (2) @(posedge mclk);
    #1 check({early_tone_flag, validated_digit_flag}, 2'b11);
  endtask

  task automatic tone_off;
    @(posedge mclk);
    tone_present <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check({early_tone_flag, validated_digit_flag}, 2'b01);
    repeat (GUARD_OFF + 4) @(posedge mclk);
    #1 check({early_tone_flag, validated_digit_flag}, 2'b00);
  endtask

  initial begin
    rstn             = 1'b0;
    tone_present     = 1'b0;
    tone_pair        = 4'h0;
    energy_detect_in = 1'b0;
    repeat (12) @(posedge mclk);
    check({serial_digit_out, early_tone_flag, validated_digit_flag}, 4'h0);
    rstn <= 1'b1;
    repeat (10) @(posedge mclk);
    foreach (rows[k]) begin
      tone_on(rows[k].pair, rows[k].energy);
      u_mcu.read_digit(got);
      check(got, rows[k].code);
      #1 check(serial_digit_out, rows[k].energy);
      tone_off;
    end
    // Fifth pulse with no new steering rise leaves the cadence in place
    u_mcu.pulse(extra_bit);
    check(extra_bit, 1'b1);
    // Tone shorter than the guard time
    @(posedge mclk);
    tone_present <= 1'b1;
    repeat (4) @(posedge mclk);
    tone_present <= 1'b0;
    for (int i = 0; i < GUARD_ON + 4; i++) begin
      @(posedge mclk);
      #1 check(validated_digit_flag, 1'b0);
    end
    // Half a readout, new digit steered in, then the rest of the old one
    tone_on(4'h5, 1'b0);
    repeat (10) @(posedge readout_clk);
    u_mcu.pulse(bits[0]);
    u_mcu.pulse(bits[1]);
    tone_off;
    tone_on(4'ha, 1'b0);
    repeat (10) @(posedge readout_clk);
    u_mcu.pulse(bits[2]);
    u_mcu.pulse(bits[3]);
    check(bits, 4'h5);
    u_mcu.read_digit(got);
    check(got, 4'h9);
    tone_off;
    // Power-down in mid-readout, digit changed meanwhile
    tone_on(4'h0, 1'b1);
    repeat (10) @(posedge readout_clk);
    u_mcu.pulse(bits[0]);
    u_mcu.set_power_down(1'b1);
    repeat (20) @(posedge mclk);
    #1 check({serial_digit_out, early_tone_flag, validated_digit_flag}, 4'h0);
    @(posedge mclk);
    tone_pair <= 4'hd;
    u_mcu.set_power_down(1'b0);
    repeat (GUARD_ON + 20) @(posedge mclk);
    #1 check(validated_digit_flag, 1'b1);
    u_mcu.read_digit(got);
    check(got, 4'ha);
    tone_off;
    print_verdict;
  end

  initial begin
    #200us;
    failures++;
    $display("[ERR] t=%0t watchdog expired seen=%h expected=%h", $time, 1'b0, 1'b1);
    print_verdict;
  end
endmodule
`default_nettype wire

// ===== tone_digit_serial_readout.sv
`include "tone_readout_cfg.svh"
`default_nettype none
module tone_digit_serial_readout #(
  parameter bit VALIDATED_STEER  = 1'b1,
  parameter int GUARD_ON_CYCLES  = `GUARD_ON_US * `MCLK_MHZ,
  parameter int GUARD_OFF_CYCLES = `GUARD_OFF_US * `MCLK_MHZ
) (
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic                          readout_clk,
  input  wire logic                          power_down_in,
  input  wire logic                          tone_present,
  input  wire tone_readout_pkg::tone_pair_type tone_pair,
  input  wire logic                          energy_detect_in,
  input  wire logic                          shift_pulse_in,
  output logic                               early_tone_flag,
  output logic                               validated_digit_flag,
  output logic                               serial_digit_out
);
  import tone_readout_pkg::*;

  localparam logic [`GUARD_CNT_BITS-1:0] GUARD_ON_LAST  = `GUARD_CNT_BITS'(GUARD_ON_CYCLES - 1);
  localparam logic [`GUARD_CNT_BITS-1:0] GUARD_OFF_LAST = `GUARD_CNT_BITS'(GUARD_OFF_CYCLES - 1);
  localparam logic [`PULSE_CNT_BITS-1:0] LAST_PULSE     = `PULSE_CNT_BITS'(`ACK_PULSES);
  localparam logic [`PULSE_CNT_BITS-1:0] NO_PULSE       = 3'h0;
  localparam logic [`PULSE_CNT_BITS-1:0] FIRST_PULSE    = 3'h1;

  // ---------------- Core clock domain ----------------

  logic [2:0]                  pd_sync;
  logic                        pd_level;
  guard_state_type             guard_state;
  logic [`GUARD_CNT_BITS-1:0]  guard_count;
  logic                        steer_now;
  logic                        steer_prev;
  logic                        steer_rise;
  digit_type                   digit_hold;
  logic [`GUARD_CNT_BITS-1:0]  tone_run;

  // Power-down pin, three stages; level moves once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pd_sync <= 3'h0;
    end else begin
      pd_sync <= {pd_sync[1:0], power_down_in};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pd_level <= 1'b0;
    end else if (pd_sync[1] == pd_sync[2]) begin
      pd_level <= pd_sync[2];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      early_tone_flag <= 1'b0;
    end else begin
      early_tone_flag <= tone_present && !pd_level;
    end
  end

  // Presence guard, then absence guard before the validated flag drops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      guard_state          <= GUARD_IDLE;
      guard_count          <= 16'h0000;
      validated_digit_flag <= 1'b0;
    end else if (pd_level) begin
      guard_state          <= GUARD_IDLE;
      guard_count          <= 16'h0000;
      validated_digit_flag <= 1'b0;
    end else begin
      case (guard_state)
        GUARD_IDLE: begin
          guard_count <= 16'h0000;
          if (tone_present) begin
            guard_state <= GUARD_CONFIRM;
          end
        end
        GUARD_CONFIRM: begin
          if (!tone_present) begin
            guard_state <= GUARD_IDLE;
          end else if (guard_count == GUARD_ON_LAST) begin
            guard_state          <= GUARD_VALID;
            validated_digit_flag <= 1'b1;
          end else begin
            guard_count <= guard_count + 16'h0001;
          end
        end
        GUARD_VALID: begin
          guard_count <= 16'h0000;
          if (!tone_present) begin
            guard_state <= GUARD_RELEASE;
          end
        end
        GUARD_RELEASE: begin
          if (tone_present) begin
            guard_state <= GUARD_VALID;
          end else if (guard_count == GUARD_OFF_LAST) begin
            guard_state          <= GUARD_IDLE;
            validated_digit_flag <= 1'b0;
          end else begin
            guard_count <= guard_count + 16'h0001;
          end
        end
        default: begin
          guard_state          <= GUARD_IDLE;
          guard_count          <= 16'h0000;
          validated_digit_flag <= 1'b0;
        end
      endcase
    end
  end

  assign steer_now  = VALIDATED_STEER ? validated_digit_flag : early_tone_flag;
  assign steer_rise = steer_now && !steer_prev;

  // Digit is frozen at the steering rise and only changes at the next one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      steer_prev <= 1'b0;
      digit_hold <= 4'h0;
    end else begin
      steer_prev <= steer_now;
      if (steer_rise) begin
        digit_hold <= tone_digit(tone_pair);
      end
    end
  end

  // Run length of tone presence, watched by the guard check only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tone_run <= 16'h0000;
    end else if (!tone_present) begin
      tone_run <= 16'h0000;
    end else if (tone_run != 16'hffff) begin
      tone_run <= tone_run + 16'h0001;
    end
  end

  // ---------------- Readout clock domain ----------------

  logic [1:0]                  link_rst_sync;
  logic                        link_rstn;
  logic [`LK_WIDTH-1:0]        lk_in;
  logic [`LK_WIDTH-1:0]        lk_s1;
  logic [`LK_WIDTH-1:0]        lk_s2;
  logic [`LK_WIDTH-1:0]        lk_s3;
  logic [`LK_WIDTH-1:0]        lk_level;
  logic [`LK_WIDTH-1:0]        lk_prev;
  logic                        ack_rise;
  logic                        ack_fall;
  logic                        arm_rise;
  logic                        pd_link;
  logic                        cadence;
  logic [`PULSE_CNT_BITS-1:0]  pulse_count;
  logic                        armed;
  logic                        reading;
  digit_type                   shreg;
  logic                        data_bit;
  logic                        cap_lsb;
  logic                        shift_lsb;

  // Reset asserts at once, releases on the readout clock
  always_ff @(posedge readout_clk or negedge rstn) begin
    if (!rstn) begin
      link_rst_sync <= 2'h0;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end

  assign link_rstn          = link_rst_sync[1];
  assign lk_in[`LK_ACK]    = shift_pulse_in;
  assign lk_in[`LK_STEER]  = steer_prev;
  assign lk_in[`LK_ENERGY] = energy_detect_in;
  assign lk_in[`LK_PD]     = pd_level;

  always_ff @(posedge readout_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      lk_s1   <= 4'h0;
      lk_s2   <= 4'h0;
      lk_s3   <= 4'h0;
      lk_prev <= 4'h0;
    end else begin
      lk_s1   <= lk_in;
      lk_s2   <= lk_s1;
      lk_s3   <= lk_s2;
      lk_prev <= lk_level;
    end
  end

  // Level follows only where stages two and three agree
  always_ff @(posedge readout_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      lk_level <= 4'h0;
    end else begin
      lk_level <= (lk_s2 & lk_s3) | (lk_level & (lk_s2 ^ lk_s3));
    end
  end

  assign ack_rise = lk_level[`LK_ACK] && !lk_prev[`LK_ACK];
  assign ack_fall = !lk_level[`LK_ACK] && lk_prev[`LK_ACK];
  assign arm_rise = lk_level[`LK_STEER] && !lk_prev[`LK_STEER];
  assign pd_link  = lk_level[`LK_PD];
  assign cadence  = lk_level[`LK_ENERGY];
  assign cap_lsb   = digit_hold[0];
  assign shift_lsb = shreg[0];

  // Armed by a steering rise, spent by a capture; a rise wins over a capture
  always_ff @(posedge readout_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      armed <= 1'b0;
    end else if (pd_link) begin
      armed <= 1'b0;
    end else if (arm_rise) begin
      armed <= 1'b1;
    end else if (ack_rise && pulse_count == NO_PULSE) begin
      armed <= 1'b0;
    end
  end

  // Steering is stable for several readout cycles before armed, so digit_hold is quiet here
  always_ff @(posedge readout_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      pulse_count <= NO_PULSE;
      reading     <= 1'b0;
      shreg       <= 4'h0;
      data_bit    <= 1'b0;
    end else if (pd_link) begin
      pulse_count <= NO_PULSE;
      reading     <= 1'b0;
      shreg       <= 4'h0;
      data_bit    <= 1'b0;
    end else if (ack_rise && pulse_count == NO_PULSE && armed) begin
      data_bit    <= digit_hold[0];
      shreg       <= digit_hold >> 1;
      pulse_count <= FIRST_PULSE;
      reading     <= 1'b1;
    end else if (ack_rise && pulse_count != NO_PULSE && pulse_count != LAST_PULSE) begin
      data_bit    <= shreg[0];
      shreg       <= shreg >> 1;
      pulse_count <= pulse_count + 3'h1;
    end else if (ack_fall && pulse_count == LAST_PULSE) begin
      pulse_count <= NO_PULSE;
      reading     <= 1'b0;
    end
  end

  always_ff @(posedge readout_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      serial_digit_out <= 1'b0;
    end else if (pd_link) begin
      serial_digit_out <= 1'b0;
    end else begin
      serial_digit_out <= reading ? data_bit : cadence;
    end
  end

  // ---------------- Checks ----------------

  AST_DIGIT_CODE:
    assert property (@(posedge mclk) disable iff (!rstn)
      steer_rise |=> digit_hold == tone_digit($past(tone_pair)))
    else $error("captured digit code does not match tone pair");

  AST_EARLY_FOLLOWS:
    assert property (@(posedge mclk) disable iff (!rstn)
      ##1 early_tone_flag == ($past(tone_present) && !$past(pd_level)))
    else $error("early flag does not follow tone presence");

  AST_GUARD_MET:
    assert property (@(posedge mclk) disable iff (!rstn)
      $rose(validated_digit_flag) |-> tone_run > GUARD_ON_LAST + 16'h0001)
    else $error("validated flag rose before guard time");

  AST_PD_FLAGS_LOW:
    assert property (@(posedge mclk) disable iff (!rstn)
      pd_level |=> !early_tone_flag && !validated_digit_flag)
    else $error("steering flag high in power-down");

  AST_ACK_EDGE:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      ack_rise |-> $past(lk_s2[`LK_ACK]) && lk_s3[`LK_ACK] && !lk_prev[`LK_ACK])
    else $error("shift pulse edge seen without agreeing stages");

  AST_CAPTURE_LSB:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      ack_rise && pulse_count == NO_PULSE && armed && !pd_link
      |=> reading && pulse_count == FIRST_PULSE && data_bit == $past(cap_lsb) ##1
          serial_digit_out == $past(data_bit))
    else $error("first pulse did not capture and show bit zero");

  AST_SHIFT_NEXT:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      ack_rise && pulse_count inside {3'h1, 3'h2, 3'h3} && !pd_link
      |=> data_bit == $past(shift_lsb) && pulse_count == $past(pulse_count) + 3'h1)
    else $error("shift pulse did not advance the digit");

  AST_BUSY_NO_CAPTURE:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      pulse_count != NO_PULSE && !pd_link |=> pulse_count != NO_PULSE || !reading)
    else $error("readout restarted before sequence ended");

  AST_EXTRA_IGNORED:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      ack_rise && (pulse_count == LAST_PULSE || (pulse_count == NO_PULSE && !armed))
      |=> $stable(data_bit) && $stable(shreg) && $stable(reading))
    else $error("extra shift pulse changed the readout");

  AST_SEQ_END:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      ack_fall && pulse_count == LAST_PULSE && !pd_link |=> !reading ##1
      serial_digit_out == $past(cadence))
    else $error("output not returned to cadence after fourth pulse");

  AST_CADENCE_ROUTE:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      !reading && !pd_link |=> serial_digit_out == $past(cadence))
    else $error("cadence not routed to serial output");

  AST_PD_CLEARS:
    assert property (@(posedge readout_clk) disable iff (!link_rstn)
      pd_link |=> pulse_count == NO_PULSE && !reading && !armed && !serial_digit_out)
    else $error("power-down left readout state set");

endmodule
`default_nettype wire

// ===== tone_readout_cfg.svh
`ifndef TONE_READOUT_CFG_SVH
`define TONE_READOUT_CFG_SVH

// Core clock rate
`define MCLK_MHZ 100

// Validation guard times, tone present and tone absent
`define GUARD_ON_US 40
`define GUARD_OFF_US 20
`define GUARD_CNT_BITS 16

// Digit and readout sequence
`define DIGIT_BITS 4
`define PAIR_SEL_BITS 2
`define ACK_PULSES 4
`define PULSE_CNT_BITS 3

// Bit positions of the inputs synchronised into the readout domain
`define LK_ACK 0
`define LK_STEER 1
`define LK_ENERGY 2
`define LK_PD 3
`define LK_WIDTH 4

`endif

// ===== tone_readout_pkg.sv
`include "tone_readout_cfg.svh"
`default_nettype none
package tone_readout_pkg;

  typedef logic [`DIGIT_BITS-1:0] digit_type;

  // Row selects the low-group tone, col the high-group tone
  typedef struct packed {
    logic [`PAIR_SEL_BITS-1:0] row;
    logic [`PAIR_SEL_BITS-1:0] col;
  } tone_pair_type;

  typedef enum logic [1:0] {
    GUARD_IDLE,
    GUARD_CONFIRM,
    GUARD_VALID,
    GUARD_RELEASE
  } guard_state_type;

  function automatic digit_type tone_digit(input tone_pair_type pair);
    digit_type code;
    case ({pair.row, pair.col})
      4'h0: code = 4'h1;
      4'h1: code = 4'h2;
      4'h2: code = 4'h3;
      4'h3: code = 4'hd;
      4'h4: code = 4'h4;
      4'h5: code = 4'h5;
      4'h6: code = 4'h6;
      4'h7: code = 4'he;
      4'h8: code = 4'h7;
      4'h9: code = 4'h8;
      4'ha: code = 4'h9;
      4'hb: code = 4'hf;
      4'hc: code = 4'hb;
      4'hd: code = 4'ha;
      4'he: code = 4'hc;
      4'hf: code = 4'h0;
      default: code = 4'h0;
    endcase
    return code;
  endfunction

endpackage
`default_nettype wire
